// File: common/mrf_regs.svh
// Purpose: Named offsets, fields and reset values of the register file
// Assumes: Included by the package and by the register file top
// Notes: Definitions only
`ifndef MRF_REGS_SVH
`define MRF_REGS_SVH

// Data addresses of the special registers
`define MRF_A_WIN 6'h00
`define MRF_A_TICK 6'h01
`define MRF_A_PCLO 6'h02
`define MRF_A_STAT 6'h03
`define MRF_A_PTR 6'h04
`define MRF_A_PRTA 6'h05
`define MRF_A_PRTB 6'h06
`define MRF_A_PWR 6'h08
`define MRF_A_PCHB 6'h0A
`define MRF_A_PDN 6'h0B
`define MRF_A_ODR 6'h0C
`define MRF_A_PUP 6'h0D
`define MRF_A_IEN 6'h0E
`define MRF_A_IFL 6'h0F
// General purpose bytes: the lone scratch byte and the start of the block
`define MRF_A_SCR 6'h07
`define MRF_A_GEN 6'h10

// Read masks: ones forced, then bits kept
`define MRF_PTR_ONES 8'hC0
`define MRF_PWR_ONES 8'h1F
`define MRF_IEN_ONES 8'h78
`define MRF_PCHB_KEEP 8'h03
`define MRF_PDN_KEEP 8'h7F
`define MRF_ODR_KEEP 8'hF7
`define MRF_IFL_KEEP 8'h07

// Program counter vectors
`define MRF_RESET_VEC 10'h3FF
`define MRF_HW_VEC 10'h008
`define MRF_SW_VEC 10'h002

// Timer configuration word fields
`define MRF_CFG_SRC 5
`define MRF_CFG_EDGE 4
`define MRF_CFG_ASSIGN 3
`define MRF_CFG_RATIO_HI 2

// Reset values and widths
`define MRF_CFG_RST 8'hFF
`define MRF_DIR_RST 8'hFF
`define MRF_BYTE_ZERO 8'h00
`define MRF_BYTE_ONES 8'hFF
`define MRF_PTR_RST 6'h00
`define MRF_WORDS 64
`endif

// File: common/mrf_pkg.sv
// Purpose: Types of the register file and tick counter
// Assumes: Constants come from the register header
// Notes: The whole module state is one packed struct
`include "mrf_regs.svh"
package mrf_pkg;
    typedef logic [7:0] mrf_byte_t;

    typedef struct packed {
        logic [9:0] pc;
        logic [5:0] ptr;
        mrf_byte_t tick;
        mrf_byte_t pre;
        mrf_byte_t cfg;
        mrf_byte_t dir_a;
        mrf_byte_t dir_b;
        mrf_byte_t rd;
        logic pin_q;
        logic wrap;
        logic [`MRF_WORDS-1:0][7:0] mem;
    } mrf_state_t;
endpackage : mrf_pkg

// File: rtl/mrf_top.sv
// Purpose: Data memory, special register decode, program counter and tick counter
// Assumes: One clock is one instruction cycle; all inputs synchronous to clk
// Notes: Read data appears one cycle after the read strobe
`include "mrf_regs.svh"
module mrf_top
    import mrf_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [5:0] addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic cfg_wr,
    input wire logic dir_wr,
    input wire logic pc_jump,
    input wire logic [9:0] pc_target,
    input wire logic hw_irq_take,
    input wire logic sw_irq_take,
    input wire logic tick_ext_clock_pin,
    output logic [7:0] rd_data,
    output logic [9:0] pc,
    output logic [7:0] tick_count,
    output logic [7:0] prescale_count,
    output logic tick_wrap,
    output logic [7:0] timer_config_word,
    output logic [7:0] port_a_direction,
    output logic [7:0] port_b_direction
);

    mrf_state_t r;
    mrf_state_t next_r;
    logic [5:0] ea;
    logic src_evt;
    logic adv;
    logic [7:0] ratio_mask;

    // Read view of one location with fixed bits applied
    function automatic mrf_byte_t view(input mrf_state_t s, input logic [5:0] a);
        mrf_byte_t v;
        v = s.mem[a];
        case (a)
            `MRF_A_WIN: v = `MRF_BYTE_ZERO;
            `MRF_A_TICK: v = s.tick;
            `MRF_A_PCLO: v = s.pc[7:0];
            `MRF_A_PTR: v = {2'b00, s.ptr} | `MRF_PTR_ONES;
            `MRF_A_PWR: v = v | `MRF_PWR_ONES;
            `MRF_A_IEN: v = v | `MRF_IEN_ONES;
            `MRF_A_PCHB: v = v & `MRF_PCHB_KEEP;
            `MRF_A_PDN: v = v & `MRF_PDN_KEEP;
            `MRF_A_ODR,
            `MRF_A_PUP: v = v & `MRF_ODR_KEEP;
            `MRF_A_IFL: v = v & `MRF_IFL_KEEP;
            default: v = s.mem[a];
        endcase
        return v;
    endfunction : view

    // Whole next state in one place
    always_comb begin
        next_r = r;
        next_r.wrap = 1'b0;
        // Address zero is redirected through the pointer
        ea = (addr == `MRF_A_WIN) ? r.ptr : addr;
        if (rd_en) begin
            next_r.rd = view(r, ea);
        end
        // Pin edge sampled against last cycle's level
        if (r.cfg[`MRF_CFG_EDGE]) begin
            src_evt = r.pin_q & ~tick_ext_clock_pin;
        end else begin
            src_evt = ~r.pin_q & tick_ext_clock_pin;
        end
        if (!r.cfg[`MRF_CFG_SRC]) begin
            src_evt = 1'b1;
        end
        next_r.pin_q = tick_ext_clock_pin;
        // Ratio 2 to the power of field plus one
        ratio_mask = 8'((9'h002 << r.cfg[`MRF_CFG_RATIO_HI:0]) - 9'h001);
        adv = 1'b0;
        if (src_evt) begin
            if (!r.cfg[`MRF_CFG_ASSIGN]) begin
                next_r.pre = r.pre + 8'h01;
                adv = ((r.pre & ratio_mask) == ratio_mask);
            end else begin
                adv = 1'b1;
            end
        end
        if (adv) begin
            next_r.tick = r.tick + 8'h01;
            next_r.wrap = (r.tick == `MRF_BYTE_ONES);
        end
        // Program counter advances by one in every instruction cycle it is not loaded below
        next_r.pc = r.pc + 10'h001;
        // Register writes; the window onto itself stores nothing
        if (wr_en && ea != `MRF_A_WIN) begin
            next_r.mem[ea] = wr_data;
            case (ea)
                `MRF_A_TICK: begin
                    next_r.tick = wr_data;
                    next_r.wrap = 1'b0;
                    if (!r.cfg[`MRF_CFG_ASSIGN]) begin
                        next_r.pre = `MRF_BYTE_ZERO;
                    end
                end
                `MRF_A_PCLO: begin
                    next_r.pc = {r.mem[`MRF_A_PCHB][1:0], wr_data};
                end
                `MRF_A_PTR: begin
                    next_r.ptr = wr_data[5:0];
                end
                default: begin
                end
            endcase
        end
        // Branch target overrides sequential flow
        if (pc_jump) begin
            next_r.pc = pc_target;
        end
        if (sw_irq_take) begin
            next_r.pc = `MRF_SW_VEC;
        end
        if (hw_irq_take) begin
            next_r.pc = `MRF_HW_VEC;
        end
        // Dedicated loads; operand picks port A or B
        if (cfg_wr) begin
            next_r.cfg = wr_data;
        end
        if (dir_wr && addr == `MRF_A_PRTA) begin
            next_r.dir_a = wr_data;
        end
        if (dir_wr && addr == `MRF_A_PRTB) begin
            next_r.dir_b = wr_data;
        end
    end

    // State register; memory content is cleared for repeatable sims
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.pc <= `MRF_RESET_VEC;
            r.ptr <= `MRF_PTR_RST;
            r.cfg <= `MRF_CFG_RST;
            r.dir_a <= `MRF_DIR_RST;
            r.dir_b <= `MRF_DIR_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from state flops
    assign rd_data = r.rd;
    assign pc = r.pc;
    assign tick_count = r.tick;
    assign prescale_count = r.pre;
    assign tick_wrap = r.wrap;
    assign timer_config_word = r.cfg;
    assign port_a_direction = r.dir_a;
    assign port_b_direction = r.dir_b;

    // Checks on vectors and program flow
    a_reset_vector: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> pc == `MRF_RESET_VEC)
        else $error("pc not at reset vector");
    a_hw_vector: assert property (
        @(posedge clk) disable iff (!nrst)
        hw_irq_take |=> pc == `MRF_HW_VEC)
        else $error("hardware vector missed");
    a_sw_vector: assert property (
        @(posedge clk) disable iff (!nrst)
        sw_irq_take && !hw_irq_take |=> pc == `MRF_SW_VEC)
        else $error("software vector missed");
    a_jump_target: assert property (
        @(posedge clk) disable iff (!nrst)
        pc_jump && !hw_irq_take && !sw_irq_take |=> pc == $past(pc_target))
        else $error("jump target not loaded");
    a_low_byte_pc: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_en && ea == `MRF_A_PCLO && !pc_jump && !hw_irq_take && !sw_irq_take
        |=> pc == {$past(r.mem[`MRF_A_PCHB][1:0]), $past(wr_data)})
        else $error("low byte write pc wrong");
    a_pc_step: assert property (
        @(posedge clk) disable iff (!nrst)
        !wr_en && !pc_jump && !hw_irq_take && !sw_irq_take
        |=> pc == $past(pc) + 10'h001)
        else $error("pc did not step");
    a_pc_write_step: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_en && ea != `MRF_A_PCLO && !pc_jump && !hw_irq_take && !sw_irq_take
        |=> pc == $past(pc) + 10'h001)
        else $error("pc did not step past a write");

    // Checks on the indirect window, the pointer and direct data bytes
    a_self_read_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && addr == `MRF_A_WIN && r.ptr == `MRF_PTR_RST
        |=> rd_data == `MRF_BYTE_ZERO)
        else $error("window self read not zero");
    a_indirect_read: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && addr == `MRF_A_WIN && r.ptr >= `MRF_A_GEN
        |=> rd_data == $past(r.mem[r.ptr]))
        else $error("indirect read wrong byte");
    a_self_write_none: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_en && addr == `MRF_A_WIN && r.ptr == `MRF_PTR_RST
        |=> r.mem == $past(r.mem))
        else $error("window self write stored");
    a_ptr_ones: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && addr == `MRF_A_PTR |=> rd_data[7:6] == 2'b11)
        else $error("pointer top bits not ones");
    a_indirect_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_en && addr == `MRF_A_WIN && r.ptr >= `MRF_A_GEN
        |=> r.mem[$past(r.ptr)] == $past(wr_data))
        else $error("indirect write missed byte");
    a_direct_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_en && (addr >= `MRF_A_GEN || addr == `MRF_A_SCR)
        |=> r.mem[$past(addr)] == $past(wr_data))
        else $error("direct write missed byte");
    a_direct_read: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && addr >= `MRF_A_GEN
        |=> rd_data == $past(r.mem[addr]))
        else $error("direct read wrong byte");
    a_ptr_low_bits: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_en && ea == `MRF_A_PTR
        |=> r.ptr == $past(wr_data[5:0]))
        else $error("pointer not loaded from low bits");
    a_self_write_ptr: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_en && addr == `MRF_A_WIN && r.ptr == `MRF_PTR_RST
        |=> $stable(r.ptr))
        else $error("window self write moved pointer");

    // Checks on fixed read bits, seen through direct or indirect reads
    a_pwr_ones: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && ea == `MRF_A_PWR |=> (rd_data & `MRF_PWR_ONES) == `MRF_PWR_ONES)
        else $error("power control star bits not ones");
    a_ien_ones: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && ea == `MRF_A_IEN |=> (rd_data & `MRF_IEN_ONES) == `MRF_IEN_ONES)
        else $error("irq enable star bits not ones");
    a_pchb_zeros: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && ea == `MRF_A_PCHB |=> (rd_data & ~`MRF_PCHB_KEEP) == `MRF_BYTE_ZERO)
        else $error("high buffer dash bits not zero");
    a_pdn_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && ea == `MRF_A_PDN |=> (rd_data & ~`MRF_PDN_KEEP) == `MRF_BYTE_ZERO)
        else $error("pull down spare bit not zero");
    a_ifl_zeros: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && ea == `MRF_A_IFL |=> (rd_data & ~`MRF_IFL_KEEP) == `MRF_BYTE_ZERO)
        else $error("irq flag dash bits not zero");
    a_odr_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_en && (ea == `MRF_A_ODR || ea == `MRF_A_PUP)
        |=> (rd_data & ~`MRF_ODR_KEEP) == `MRF_BYTE_ZERO)
        else $error("drive control spare bit not zero");

    // Checks on the tick counter, the config word and the port directions
    a_pre_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_en && ea == `MRF_A_TICK && !r.cfg[`MRF_CFG_ASSIGN]
        |=> prescale_count == `MRF_BYTE_ZERO ##0 tick_count == $past(wr_data))
        else $error("tick write did not clear prescaler");
    a_tick_wrap: assert property (
        @(posedge clk) disable iff (!nrst)
        adv && tick_count == `MRF_BYTE_ONES && !(wr_en && ea == `MRF_A_TICK)
        |=> tick_count == `MRF_BYTE_ZERO && tick_wrap)
        else $error("tick did not wrap");
    a_cycle_source: assert property (
        @(posedge clk) disable iff (!nrst)
        !r.cfg[`MRF_CFG_SRC] && r.cfg[`MRF_CFG_ASSIGN] && !(wr_en && ea == `MRF_A_TICK)
        |=> tick_count == $past(tick_count) + 8'h01)
        else $error("cycle clock did not count");
    a_dir_load: assert property (
        @(posedge clk) disable iff (!nrst)
        dir_wr && addr == `MRF_A_PRTB |=> port_b_direction == $past(wr_data))
        else $error("direction not loaded");
    a_cfg_load: assert property (
        @(posedge clk) disable iff (!nrst)
        cfg_wr |=> timer_config_word == $past(wr_data))
        else $error("config word not loaded");
    a_cfg_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !cfg_wr |=> $stable(timer_config_word))
        else $error("config word changed without its load");
    a_dir_a_load: assert property (
        @(posedge clk) disable iff (!nrst)
        dir_wr && addr == `MRF_A_PRTA |=> port_a_direction == $past(wr_data))
        else $error("port a direction not loaded");
    a_dir_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !(dir_wr && (addr == `MRF_A_PRTA || addr == `MRF_A_PRTB))
        |=> $stable(port_a_direction) && $stable(port_b_direction))
        else $error("direction changed without its load");
    a_pin_idle: assert property (
        @(posedge clk) disable iff (!nrst)
        r.cfg[`MRF_CFG_SRC] && tick_ext_clock_pin == r.pin_q && !(wr_en && ea == `MRF_A_TICK)
        |=> $stable(tick_count))
        else $error("pin source counted without an edge");
    a_rise_count: assert property (
        @(posedge clk) disable iff (!nrst)
        r.cfg[`MRF_CFG_SRC] && !r.cfg[`MRF_CFG_EDGE] && r.cfg[`MRF_CFG_ASSIGN]
        && !r.pin_q && tick_ext_clock_pin && !(wr_en && ea == `MRF_A_TICK)
        |=> tick_count == $past(tick_count) + 8'h01)
        else $error("rising pin edge not counted");
    a_fall_count: assert property (
        @(posedge clk) disable iff (!nrst)
        r.cfg[`MRF_CFG_SRC] && r.cfg[`MRF_CFG_EDGE] && r.cfg[`MRF_CFG_ASSIGN]
        && r.pin_q && !tick_ext_clock_pin && !(wr_en && ea == `MRF_A_TICK)
        |=> tick_count == $past(tick_count) + 8'h01)
        else $error("falling pin edge not counted");
    a_pre_count: assert property (
        @(posedge clk) disable iff (!nrst)
        !r.cfg[`MRF_CFG_ASSIGN] && !r.cfg[`MRF_CFG_SRC] && !(wr_en && ea == `MRF_A_TICK)
        |=> prescale_count == $past(prescale_count) + 8'h01)
        else $error("prescaler did not count");
    a_pre_idle: assert property (
        @(posedge clk) disable iff (!nrst)
        r.cfg[`MRF_CFG_ASSIGN] |=> $stable(prescale_count))
        else $error("unassigned prescaler moved");
    a_tick_load: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_en && ea == `MRF_A_TICK |=> tick_count == $past(wr_data) && !tick_wrap)
        else $error("tick write not loaded");
    a_no_wrap: assert property (
        @(posedge clk) disable iff (!nrst)
        !adv || tick_count != `MRF_BYTE_ONES |=> !tick_wrap)
        else $error("wrap pulse without a wrap");

    // Main scenarios
    c_indirect_rd: cover property (
        @(posedge clk) disable iff (!nrst)
        rd_en && addr == `MRF_A_WIN && r.ptr != `MRF_PTR_RST);
    c_pin_count: cover property (
        @(posedge clk) disable iff (!nrst)
        r.cfg[`MRF_CFG_SRC] && adv);
    c_wrap: cover property (
        @(posedge clk) disable iff (!nrst)
        tick_wrap);
    c_hw_irq: cover property (
        @(posedge clk) disable iff (!nrst)
        hw_irq_take);
    c_pre_adv: cover property (
        @(posedge clk) disable iff (!nrst)
        !r.cfg[`MRF_CFG_ASSIGN] && adv);

endmodule : mrf_top

// File: sim/mrf_pin_model.sv
// Purpose: Core-side model that drives the external tick pin
// Assumes: Pin is a synchronous level, changed at falling clock edges
// Notes: Pin idles low until the bench asks for a level
module mrf_pin_model (
    input wire logic clk,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle low so the first configured edge is a known one
    initial begin
        pin = 1'b0;
    end

    // New level, then two edges so the sampled copy catches up
    task automatic set(input logic v);
        @(negedge clk);
        pin = v;
        repeat (2) @(negedge clk);
    endtask : set
endmodule : mrf_pin_model

// File: sim/mrf_top_tb.sv
// Purpose: Self-checking bench of the register file and tick counter
// Assumes: Inputs change at falling edges, design samples on rising
// Notes: Watchdog cuts a hang after a span far above the test length
module mrf_top_tb
    import mrf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, rd_en, wr_en, cfg_wr, dir_wr, pc_jump, hw_irq_take, sw_irq_take;
    logic tick_wrap;
    logic [5:0] addr;
    logic [7:0] wr_data, rd_data, tick_count, prescale_count;
    logic [7:0] timer_config_word, port_a_direction, port_b_direction;
    logic [9:0] pc_target, pc;
    wire pin;
    int miscompares = 0;
    int n_compared = 0;

    mrf_top i_mrf_top (.clk(clk), .nrst(nrst), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
        .wr_data(wr_data), .cfg_wr(cfg_wr), .dir_wr(dir_wr), .pc_jump(pc_jump),
        .pc_target(pc_target), .hw_irq_take(hw_irq_take), .sw_irq_take(sw_irq_take),
        .tick_ext_clock_pin(pin), .rd_data(rd_data), .pc(pc), .tick_count(tick_count),
        .prescale_count(prescale_count), .tick_wrap(tick_wrap),
        .timer_config_word(timer_config_word), .port_a_direction(port_a_direction),
        .port_b_direction(port_b_direction));
    mrf_pin_model i_mrf_pin_model (.clk(clk), .pin(pin));

    // Free-running instruction clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic summarize();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Bus cycles: strobe for one rising edge, result settled at next fall
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        check("rd_data", {2'b00, rd_data}, {2'b00, exp});
    endtask : rd

    task automatic cfg(input logic [7:0] d);
        @(negedge clk);
        wr_data = d;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : cfg

    task automatic dir(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wr_data = d;
        dir_wr = 1'b1;
        @(negedge clk);
        dir_wr = 1'b0;
    endtask : dir

    // Watchdog: whole sequence needs well under 200 cycles
    initial begin
        #20000;
        miscompares++;
        summarize();
    end

    // Main sequence
    initial begin
        {nrst, rd_en, wr_en, cfg_wr, dir_wr, pc_jump, hw_irq_take, sw_irq_take} = 8'h00;
        addr = 6'h00;
        wr_data = 8'h00;
        pc_target = 10'h000;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        check("pc", pc, 10'h3FF);
        @(negedge clk);
        check("pc", pc, 10'h000);
        hw_irq_take = 1'b1;
        @(negedge clk);
        hw_irq_take = 1'b0;
        sw_irq_take = 1'b1;
        check("pc", pc, 10'h008);
        @(negedge clk);
        sw_irq_take = 1'b0;
        pc_jump = 1'b1;
        pc_target = 10'h3FE;
        check("pc", pc, 10'h002);
        @(negedge clk);
        pc_jump = 1'b0;
        check("pc", pc, 10'h3FE);
        // Indirect access through the pointer, then direct bytes, fixed bits and pc low byte
        wr(6'h38, 8'h10);
        wr(6'h39, 8'h0A);
        wr(6'h04, 8'h38);
        rd(6'h00, 8'h10);
        wr(6'h04, 8'h39);
        rd(6'h00, 8'h0A);
        rd(6'h04, 8'hF9);
        wr(6'h04, 8'h40);
        rd(6'h00, 8'h00);
        wr(6'h00, 8'h5A);
        rd(6'h04, 8'hC0);
        wr(6'h07, 8'hA5);
        wr(6'h3F, 8'h3C);
        rd(6'h07, 8'hA5);
        rd(6'h3F, 8'h3C);
        wr(6'h0A, 8'hFF);
        rd(6'h0A, 8'h03);
        wr(6'h08, 8'h00);
        rd(6'h08, 8'h1F);
        wr(6'h02, 8'h55);
        check("pc", pc, 10'h355);
        // Write-only loads
        check("cfg", {2'b00, timer_config_word}, 10'h0FF);
        dir(6'h05, 8'hA5);
        dir(6'h07, 8'h3C);
        check("dir_a", {2'b00, port_a_direction}, 10'h0A5);
        dir(6'h06, 8'h0F);
        check("dir_b", {2'b00, port_b_direction}, 10'h00F);
        // Counter on cycle clock, wrap
        cfg(8'h08);
        check("cfg", {2'b00, timer_config_word}, 10'h008);
        wr(6'h01, 8'hFF);
        @(negedge clk);
        check("tick", {2'b00, tick_count}, 10'h000);
        check("wrap", {9'h000, tick_wrap}, 10'h001);
        // Prescaler assigned, cleared by counter write
        cfg(8'h00);
        wr(6'h01, 8'h20);
        check("tick", {2'b00, tick_count}, 10'h020);
        check("pre", {2'b00, prescale_count}, 10'h000);
        @(negedge clk);
        check("pre", {2'b00, prescale_count}, 10'h001);
        @(negedge clk);
        check("tick", {2'b00, tick_count}, 10'h021);
        // Pin source, rising then falling edge
        cfg(8'h28);
        wr(6'h01, 8'h00);
        i_mrf_pin_model.set(1'b1);
        check("tick", {2'b00, tick_count}, 10'h001);
        i_mrf_pin_model.set(1'b0);
        check("tick", {2'b00, tick_count}, 10'h001);
        cfg(8'h38);
        wr(6'h01, 8'h00);
        i_mrf_pin_model.set(1'b1);
        check("tick", {2'b00, tick_count}, 10'h000);
        i_mrf_pin_model.set(1'b0);
        check("tick", {2'b00, tick_count}, 10'h001);
        summarize();
    end
endmodule : mrf_top_tb
